/* verilog/bpm_map.vh */
`ifndef BPM_MAP_VH
`define BPM_MAP_VH
`define BPM_REG_VER 8'h05
`define BPM_VER_OFS 8'h03
`define BPM_A_CYC 8'h03
`define BPM_A_THR 8'h04
`define BPM_A_HYS 8'h05
`define BPM_A_OSCR 8'h06
`define BPM_A_OSCF 8'h07
`define BPM_A_CUT 8'h08
`define BPM_A_SHD 8'h0A
`define BPM_A_BOOT 8'h0C
`define BPM_A_BACK 8'h0E
`define BPM_A_OFS 8'h10
`define BPM_A_DLY 8'h12
`define BPM_A_POL 8'h14
`define BPM_A_WAKE 8'h1A
`define BPM_A_VBAT 8'h1E
`define BPM_A_HIST 8'h1F
`define BPM_A_OUTPUT_LEVEL 8'h20
`define BPM_A_STEP 8'h01
`define BPM_R_CYC 8'h14
`define BPM_R_THR 8'h0C
`define BPM_R_HYS 8'h02
`define BPM_R_OSC 8'h00
`define BPM_R_CUT 16'h123D
`define BPM_R_SHD 16'h12E1
`define BPM_R_BOOT 16'h1424
`define BPM_R_BACK 16'h165A
`define BPM_R_OFS 16'h0000
`define BPM_R_DLY 16'h0041
`define BPM_R_POL 8'h00
`define BPM_R_WAKE 16'h0000
`define BPM_POL_VBAT 8'h01
`define BPM_POL_SMART 8'h02
`define BPM_UNMAPPED 8'hFF
`define BPM_HOLD 4'hF
`define BPM_HOLD_PRE 4'h7
`define BPM_BASE_SH 3
`endif

/* verilog/bpm_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "bpm_map.vh"
module bpm_regs (
  // clock, reset, enable
  input wire clk_sys,
  input wire reset_n,
  input wire clk_en,
  // register port from the serial engine
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  // converter results, same clock
  input wire [12:0] adc_bat,
  input wire [12:0] adc_out,
  input wire adc_valid,
  // pins
  input wire tick_pin,
  input wire minute_pin,
  input wire pad_sense_pin,
  input wire host_txd_pin,
  output reg pad_drive_q,
  output reg host_power_q,
  output reg shutdown_req_q,
  output reg touch_active_q
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg [1:0] edge_q;
  wire tick_s = sync2_q[0];
  wire min_s = sync2_q[1];
  wire sense_s = sync2_q[2];
  wire txd_s = sync2_q[3];
  wire tick_evt = tick_s & ~edge_q[0];
  wire min_evt = min_s & ~edge_q[1];

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      edge_q <= 2'h0;
    end else if (clk_en) begin
      sync1_q <= {host_txd_pin, pad_sense_pin, minute_pin, tick_pin};
      sync2_q <= sync1_q;
      edge_q <= sync2_q[1:0];
    end
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg [7:0] cyc_q, thr_q, hys_q, oscr_q, oscf_q, pol_q;
  reg [15:0] cut_q, shd_q, boot_q, back_q, ofs_q, dly_q;
  reg [15:0] wake_q;
  reg [15:0] bat_q, out_q;
  reg [7:0] hist_q;
  reg wake_fire;

  function [15:0] wr16;
    input [15:0] cur;
    input [7:0] base;
    begin
      wr16 = cur;
      if (reg_wr && reg_addr == base)
        wr16 = {cur[15:8], reg_wdata};
      if (reg_wr && reg_addr == base + `BPM_A_STEP)
        wr16 = {reg_wdata, cur[7:0]};
    end
  endfunction

  function [7:0] wr8;
    input [7:0] cur;
    input [7:0] base;
    begin
      wr8 = (reg_wr && reg_addr == base) ? reg_wdata : cur;
    end
  endfunction

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cyc_q <= `BPM_R_CYC;
      thr_q <= `BPM_R_THR;
      hys_q <= `BPM_R_HYS;
      oscr_q <= `BPM_R_OSC;
      oscf_q <= `BPM_R_OSC;
      cut_q <= `BPM_R_CUT;
      shd_q <= `BPM_R_SHD;
      boot_q <= `BPM_R_BOOT;
      back_q <= `BPM_R_BACK;
      ofs_q <= `BPM_R_OFS;
      dly_q <= `BPM_R_DLY;
      pol_q <= `BPM_R_POL;
    end else if (clk_en) begin
      cyc_q <= wr8(cyc_q, `BPM_A_CYC);
      thr_q <= wr8(thr_q, `BPM_A_THR);
      hys_q <= wr8(hys_q, `BPM_A_HYS);
      oscr_q <= wr8(oscr_q, `BPM_A_OSCR);
      oscf_q <= wr8(oscf_q, `BPM_A_OSCF);
      cut_q <= wr16(cut_q, `BPM_A_CUT);
      shd_q <= wr16(shd_q, `BPM_A_SHD);
      boot_q <= wr16(boot_q, `BPM_A_BOOT);
      back_q <= wr16(back_q, `BPM_A_BACK);
      ofs_q <= wr16(ofs_q, `BPM_A_OFS);
      dly_q <= wr16(dly_q, `BPM_A_DLY);
      pol_q <= wr8(pol_q, `BPM_A_POL);
    end
  end

  // measured levels are read only, writes to them are ignored
  reg [7:0] rd_d;
  always @* begin
    case (reg_addr)
      `BPM_A_CYC: rd_d = cyc_q;
      `BPM_A_THR: rd_d = thr_q;
      `BPM_A_HYS: rd_d = hys_q;
      `BPM_A_OSCR: rd_d = oscr_q;
      `BPM_A_OSCF: rd_d = oscf_q;
      `BPM_A_CUT: rd_d = cut_q[7:0];
      `BPM_A_CUT + `BPM_A_STEP: rd_d = cut_q[15:8];
      `BPM_A_SHD: rd_d = shd_q[7:0];
      `BPM_A_SHD + `BPM_A_STEP: rd_d = shd_q[15:8];
      `BPM_A_BOOT: rd_d = boot_q[7:0];
      `BPM_A_BOOT + `BPM_A_STEP: rd_d = boot_q[15:8];
      `BPM_A_BACK: rd_d = back_q[7:0];
      `BPM_A_BACK + `BPM_A_STEP: rd_d = back_q[15:8];
      `BPM_A_OFS: rd_d = ofs_q[7:0];
      `BPM_A_OFS + `BPM_A_STEP: rd_d = ofs_q[15:8];
      `BPM_A_DLY: rd_d = dly_q[7:0];
      `BPM_A_DLY + `BPM_A_STEP: rd_d = dly_q[15:8];
      `BPM_A_POL: rd_d = pol_q;
      `BPM_A_WAKE: rd_d = wake_q[7:0];
      `BPM_A_WAKE + `BPM_A_STEP: rd_d = wake_q[15:8];
      `BPM_A_VBAT: rd_d = bat_q[7:0];
      // the history byte shadows the battery high byte at this offset
      `BPM_A_HIST: rd_d = hist_q;
      `BPM_A_OUTPUT_LEVEL: rd_d = out_q[7:0];
      `BPM_A_OUTPUT_LEVEL + `BPM_A_STEP: rd_d = out_q[15:8];
      default: rd_d = `BPM_UNMAPPED;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 8'h00;
    end else if (clk_en) begin
      reg_rdata_q <= rd_d;
    end
  end

  // ------------------------------------------------------------
  // voltage levels
  // ------------------------------------------------------------
  wire ver_full = (`BPM_REG_VER >= 8'h05);
  wire ver_ofs = (`BPM_REG_VER == `BPM_VER_OFS);
  wire [15:0] bat_w = ver_full ? {3'h0, adc_bat} : {6'h0, adc_bat[12:3]};
  wire [15:0] out_w = ver_full ? {3'h0, adc_out} : {6'h0, adc_out[12:3]};
  wire [15:0] ofs_w = ver_ofs ? ofs_q : 16'h0000;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bat_q <= 16'h0000;
      out_q <= 16'h0000;
    end else if (clk_en && adc_valid) begin
      bat_q <= bat_w + ofs_w;
      out_q <= out_w + ofs_w;
    end
  end

  // ------------------------------------------------------------
  // touch measurement
  // ------------------------------------------------------------
  localparam TM_IDLE = 3'b001;
  localparam TM_CHG = 3'b010;
  localparam TM_DIS = 3'b100;
  reg [2:0] tm_q;
  reg [7:0] left_q;
  reg [15:0] rdg_q;
  reg [15:0] base_q;
  reg base_ok_q;
  reg done;

  // reading grows with pad capacitance; saturation ends a stuck pad
  wire rdg_sat = (rdg_q == 16'hFFFF);
  wire [17:0] hi_lim = {2'h0, base_q} + {10'h0, thr_q} + {10'h0, hys_q};
  wire [17:0] lo_lhs = {2'h0, rdg_q} + {10'h0, hys_q};
  wire [17:0] lo_rhs = {2'h0, base_q} + {10'h0, thr_q};
  wire [16:0] diff = {1'b0, rdg_q} - {1'b0, base_q};
  wire [16:0] step = {{`BPM_BASE_SH{diff[16]}}, diff[16:`BPM_BASE_SH]};
  wire [15:0] base_nx = base_q + step[15:0];
  wire touch_nx = base_ok_q && (touch_active_q ? !(lo_lhs < lo_rhs)
                                               : ({2'h0, rdg_q} > hi_lim));
  wire [7:0] hist_nx = {hist_q[6:0], touch_nx};
  wire hold_evt = done && hist_nx[3:0] == `BPM_HOLD && hist_q[3:0] == `BPM_HOLD_PRE;

  always @* begin
    done = 1'b0;
    if (tm_q == TM_DIS && (!sense_s || rdg_sat) && (left_q <= 8'h01 || rdg_sat))
      done = 1'b1;
    if (tm_q == TM_CHG && (rdg_sat || left_q <= 8'h01) && (sense_s || rdg_sat))
      done = 1'b1;
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tm_q <= TM_IDLE;
      left_q <= 8'h00;
      rdg_q <= 16'h0000;
      base_q <= 16'h0000;
      base_ok_q <= 1'b0;
      hist_q <= 8'h00;
      touch_active_q <= 1'b0;
      pad_drive_q <= 1'b0;
    end else if (clk_en) begin
      case (tm_q)
        TM_IDLE: begin
          pad_drive_q <= 1'b0;
          if (tick_evt && cyc_q != 8'h00) begin
            tm_q <= TM_CHG;
            left_q <= cyc_q;
            rdg_q <= 16'h0000;
            pad_drive_q <= 1'b1;
          end
        end
        TM_CHG: begin
          if (!rdg_sat)
            rdg_q <= rdg_q + 16'h0001;
          if (sense_s || rdg_sat) begin
            left_q <= left_q - 8'h01;
            pad_drive_q <= 1'b0;
            tm_q <= (left_q <= 8'h01 || rdg_sat) ? TM_IDLE : TM_DIS;
          end
        end
        TM_DIS: begin
          if (!rdg_sat)
            rdg_q <= rdg_q + 16'h0001;
          if (!sense_s || rdg_sat) begin
            left_q <= left_q - 8'h01;
            pad_drive_q <= (left_q > 8'h01) && !rdg_sat;
            tm_q <= (left_q <= 8'h01 || rdg_sat) ? TM_IDLE : TM_CHG;
          end
        end
        default: begin
          tm_q <= TM_IDLE;
          pad_drive_q <= 1'b0;
        end
      endcase
      if (done) begin
        hist_q <= hist_nx;
        touch_active_q <= touch_nx;
        base_ok_q <= 1'b1;
        // baseline follows only an idle pad so a hold does not absorb itself
        if (!base_ok_q)
          base_q <= rdg_q;
        else if (!touch_nx)
          base_q <= base_nx;
      end
    end
  end

  // ------------------------------------------------------------
  // host power sequencing
  // ------------------------------------------------------------
  localparam PS_OFF = 4'b0001;
  localparam PS_ON = 4'b0010;
  localparam PS_SHDN = 4'b0100;
  localparam PS_WAIT = 4'b1000;
  reg [3:0] ps_q;
  reg [15:0] dcnt_q;
  reg auto_ok_q;
  reg wake_pend_q;

  wire bat_cut = bat_q < cut_q;
  wire bat_low = bat_q <= shd_q;
  wire boot_ok = (bat_q >= boot_q) && !(out_q >= back_q);
  wire boot_want = hold_evt
                 || pol_q == `BPM_POL_VBAT
                 || (pol_q == `BPM_POL_SMART && auto_ok_q)
                 || wake_pend_q;
  wire boot_go = (ps_q == PS_OFF) && boot_ok && boot_want;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ps_q <= PS_OFF;
      dcnt_q <= 16'h0000;
      auto_ok_q <= 1'b0;
      host_power_q <= 1'b0;
      shutdown_req_q <= 1'b0;
    end else if (clk_en) begin
      case (ps_q)
        PS_OFF: begin
          if (boot_go) begin
            ps_q <= PS_ON;
            host_power_q <= 1'b1;
          end
        end
        PS_ON: begin
          if (bat_cut) begin
            ps_q <= PS_OFF;
            host_power_q <= 1'b0;
            auto_ok_q <= 1'b1;
          end else if (bat_low) begin
            ps_q <= PS_SHDN;
            shutdown_req_q <= 1'b1;
            auto_ok_q <= 1'b1;
          end else if (hold_evt) begin
            ps_q <= PS_SHDN;
            shutdown_req_q <= 1'b1;
            auto_ok_q <= 1'b0;
          end
        end
        PS_SHDN: begin
          if (bat_cut) begin
            ps_q <= PS_OFF;
            host_power_q <= 1'b0;
            shutdown_req_q <= 1'b0;
            auto_ok_q <= 1'b1;
          end else if (!txd_s) begin
            ps_q <= PS_WAIT;
            dcnt_q <= dly_q;
          end
        end
        PS_WAIT: begin
          if (bat_cut || (tick_evt && dcnt_q <= 16'h0001)) begin
            ps_q <= PS_OFF;
            host_power_q <= 1'b0;
            shutdown_req_q <= 1'b0;
            if (bat_cut)
              auto_ok_q <= 1'b1;
          end else if (tick_evt) begin
            dcnt_q <= dcnt_q - 16'h0001;
          end
        end
        default: begin
          ps_q <= PS_OFF;
          host_power_q <= 1'b0;
          shutdown_req_q <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // wake timer
  // ------------------------------------------------------------
  // counts only while off, so after a boot it holds the minutes left
  always @* begin
    wake_fire = (ps_q == PS_OFF) && min_evt && wake_q == 16'h0001;
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wake_q <= `BPM_R_WAKE;
      wake_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (reg_wr && (reg_addr == `BPM_A_WAKE || reg_addr == `BPM_A_WAKE + `BPM_A_STEP))
        wake_q <= wr16(wake_q, `BPM_A_WAKE);
      else if (ps_q == PS_OFF && min_evt && wake_q != 16'h0000)
        wake_q <= wake_q - 16'h0001;
      // expiry stays pending until a boot is allowed; set beats clear
      wake_pend_q <= (wake_pend_q && !boot_go) || wake_fire;
    end
  end

endmodule
`default_nettype wire

/* bench/bpm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bpm_map.vh"
module bpm_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  // converter and host pin
  input wire logic [12:0] adc_bat,
  input wire logic [12:0] adc_out,
  input wire logic adc_valid,
  input wire logic host_txd_pin,
  // power and touch outputs
  input wire logic host_power_q,
  input wire logic shutdown_req_q,
  input wire logic touch_active_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // latched conversions
  // ----------------------------------------
  logic [12:0] bat_q;
  logic [12:0] out_q;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bat_q <= 13'h0000;
      out_q <= 13'h0000;
    end else if (adc_valid) begin
      bat_q <= adc_bat;
      out_q <= adc_out;
    end
  end
  property p_cut;
    adc_valid && adc_bat < 16'h123D |-> ##[1:3] !host_power_q;
  endproperty
  a_cut: assert property (p_cut) else $error("power kept after cutoff level");
  property p_unmapped;
    reg_addr > 8'h21 |=> reg_rdata_q == 8'hFF;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not FF");
  property p_boot;
    $rose(host_power_q) |-> $past(bat_q) >= 16'h1424;
  endproperty
  a_boot: assert property (p_boot) else $error("boot on low battery");
  property p_back;
    $rose(host_power_q) |-> $past(out_q) < 16'h165A;
  endproperty
  a_back: assert property (p_back) else $error("boot with back power");
  // txd high for a while means the sequencer cannot be in its wait phase
  property p_shd;
    host_power_q && !shutdown_req_q && host_txd_pin && $past(host_txd_pin, 3) &&
      bat_q <= 16'h12E1 && bat_q >= 16'h123D |=> shutdown_req_q || !host_power_q;
  endproperty
  a_shd: assert property (p_shd) else $error("no shutdown request on low battery");
  property p_hist;
    reg_addr == 8'h1F && touch_active_q && $past(touch_active_q) |=> reg_rdata_q != 8'h00;
  endproperty
  a_hist: assert property (p_hist) else $error("history zero during touch");
  property p_fell;
    $fell(host_power_q) |-> $past(bat_q) < 16'h123D || !$past(host_txd_pin, 3);
  endproperty
  a_fell: assert property (p_fell) else $error("power removed without cause");
  property p_wr;
    reg_wr && reg_addr == 8'h04 ##1 reg_addr == 8'h04 |=> reg_rdata_q == $past(reg_wdata, 2);
  endproperty
  a_wr: assert property (p_wr) else $error("written threshold not read back");
  cp_boot: cover property ($rose(host_power_q));
  cp_shd: cover property ($rose(shutdown_req_q));
  cp_touch: cover property ($rose(touch_active_q));
endmodule
bind bpm_regs bpm_monitor i_bpm_monitor (.clk_sys(clk_sys), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .adc_bat(adc_bat), .adc_out(adc_out), .adc_valid(adc_valid), .host_txd_pin(host_txd_pin),
  .host_power_q(host_power_q), .shutdown_req_q(shutdown_req_q),
  .touch_active_q(touch_active_q));
`default_nettype wire

/* bench/bpm_host.sv */
`timescale 1ns/1ps
`default_nettype none
module bpm_host #(parameter int HALT_CYC = 20) (
  // pad side
  input wire logic clk_sys,
  input wire logic touched,
  input wire logic pad_drive,
  output wire logic pad_sense,
  // host side
  input wire logic host_power,
  input wire logic shutdown_req,
  output wire logic host_txd
);
  int lag_q = 0;
  int halt_q = 0;
  logic sense_q = 1'b0;
  logic txd_q = 1'b0;
  assign pad_sense = sense_q;
  assign host_txd = txd_q;
  always @(posedge clk_sys) begin
    // a finger adds charge, so each phase settles later
    if (sense_q == pad_drive) lag_q <= 0;
    else if (lag_q >= (touched ? 8 : 1)) sense_q <= pad_drive;
    else lag_q <= lag_q + 1;
    // an unpowered host holds tx low; it halts a while after the request
    if (!host_power) halt_q <= 0;
    else if (shutdown_req && halt_q < HALT_CYC) halt_q <= halt_q + 1;
    txd_q <= host_power && halt_q < HALT_CYC;
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [12:0] adc_bat = 13'h0000;
  logic [12:0] adc_out = 13'h0000;
  logic adc_valid = 1'b0;
  logic tick_pin = 1'b0;
  logic minute_pin = 1'b0;
  logic touched = 1'b0;
  wire [7:0] reg_rdata_q;
  wire pad_sense_pin, host_txd_pin, pad_drive_q, host_power_q, shutdown_req_q, touch_active_q;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [15:0] rv;
  logic [15:0] n_rise;
  initial forever #2 clk_sys = ~clk_sys;
  bpm_regs i_bpm_regs (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .adc_bat(adc_bat), .adc_out(adc_out), .adc_valid(adc_valid), .tick_pin(tick_pin),
    .minute_pin(minute_pin), .pad_sense_pin(pad_sense_pin), .host_txd_pin(host_txd_pin),
    .pad_drive_q(pad_drive_q), .host_power_q(host_power_q), .shutdown_req_q(shutdown_req_q),
    .touch_active_q(touch_active_q));
  bpm_host i_bpm_host (.clk_sys(clk_sys), .touched(touched), .pad_drive(pad_drive_q),
    .pad_sense(pad_sense_pin), .host_power(host_power_q), .shutdown_req(shutdown_req_q),
    .host_txd(host_txd_pin));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic timeout();
    n_mismatch++;
    $display("unexpected at %0t: wait ran out", $time);
    final_report();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    d = reg_rdata_q;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] e, input bit wide);
    rd(a, rv[7:0]);
    rv[15:8] = 8'h00;
    if (wide) rd(a + 8'h01, rv[15:8]);
    check(rv, e);
  endtask
  task automatic adc(input logic [12:0] b, input logic [12:0] o);
    @(negedge clk_sys);
    adc_bat = b;
    adc_out = o;
    adc_valid = 1'b1;
    @(negedge clk_sys);
    adc_valid = 1'b0;
    cyc(4);
  endtask
  // waits until the pad drive has rested, i.e. the measurement is over
  task automatic tick(input logic t);
    int idle;
    logic prev;
    touched = t;
    @(negedge clk_sys);
    tick_pin = 1'b1;
    cyc(4);
    tick_pin = 1'b0;
    idle = 0;
    prev = 1'b0;
    n_rise = 16'h0000;
    for (int i = 0; i < 800 && idle < 30; i++) begin
      @(negedge clk_sys);
      // charge phases counted by rising drive
      if (pad_drive_q === 1'b1 && !prev) n_rise = n_rise + 16'h0001;
      prev = (pad_drive_q === 1'b1);
      idle = (pad_drive_q === 1'b0) ? idle + 1 : 0;
    end
    if (idle < 30) timeout();
    cyc(4);
  endtask
  task automatic minute();
    @(negedge clk_sys);
    minute_pin = 1'b1;
    cyc(4);
    minute_pin = 1'b0;
    cyc(4);
  endtask
  task automatic wait_pwr(input logic v);
    for (int i = 0; i < 40 && host_power_q !== v; i++) @(negedge clk_sys);
    if (host_power_q !== v) timeout();
    check(host_power_q, v);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_regs();
    chk_reg(8'h03, 16'h0014, 0);
    chk_reg(8'h04, 16'h000C, 0);
    chk_reg(8'h05, 16'h0002, 0);
    chk_reg(8'h08, 16'h123D, 1);
    chk_reg(8'h0A, 16'h12E1, 1);
    chk_reg(8'h0C, 16'h1424, 1);
    chk_reg(8'h0E, 16'h165A, 1);
    chk_reg(8'h10, 16'h0000, 1);
    chk_reg(8'h12, 16'h0041, 1);
    chk_reg(8'h14, 16'h0000, 0);
    chk_reg(8'h1A, 16'h0000, 1);
    chk_reg(8'h30, 16'hFFFF, 1);
    wr(8'h04, 8'h20);
    chk_reg(8'h04, 16'h0020, 0);
    wr(8'h04, 8'h0C);
    adc(13'h1424, 13'h0ABC);
    chk_reg(8'h1E, 16'h0024, 0);
    wr(8'h20, 8'h55);
    chk_reg(8'h20, 16'h0ABC, 1);
  endtask
  task automatic s_touch();
    wr16(8'h12, 16'h0003);
    wr16(8'h1A, 16'h0005);
    tick(0);
    tick(0);
    check(n_rise, 16'h000A);
    chk_reg(8'h1F, 16'h0000, 0);
    check(touch_active_q, 1'b0);
    tick(1);
    chk_reg(8'h1F, 16'h0001, 0);
    check(touch_active_q, 1'b1);
    check(host_power_q, 1'b0);
    repeat (3) tick(1);
    wait_pwr(1'b1);
    chk_reg(8'h1A, 16'h0005, 1);
    tick(0);
    chk_reg(8'h1F, 16'h001E, 0);
    check(touch_active_q, 1'b0);
    repeat (4) tick(1);
    check(shutdown_req_q, 1'b1);
    cyc(30);
    tick(0);
    tick(0);
    check(host_power_q, 1'b1);
    tick(0);
    check(host_power_q, 1'b0);
  endtask
  task automatic s_wake();
    wr16(8'h1A, 16'h0002);
    minute();
    chk_reg(8'h1A, 16'h0001, 1);
    check(host_power_q, 1'b0);
    minute();
    wait_pwr(1'b1);
    chk_reg(8'h1A, 16'h0000, 1);
  endtask
  task automatic s_lowbat();
    adc(13'h12E1, 13'h0ABC);
    check(shutdown_req_q, 1'b1);
    for (int i = 0; i < 6 && host_power_q === 1'b1; i++) tick(0);
    check(host_power_q, 1'b0);
    wr(8'h14, 8'h02);
    adc(13'h1424, 13'h0ABC);
    wait_pwr(1'b1);
  endtask
  task automatic s_cut();
    adc(13'h123C, 13'h0ABC);
    check(host_power_q, 1'b0);
    wr(8'h14, 8'h01);
    adc(13'h1423, 13'h0ABC);
    check(host_power_q, 1'b0);
    adc(13'h1424, 13'h165A);
    check(host_power_q, 1'b0);
    adc(13'h1424, 13'h1659);
    wait_pwr(1'b1);
  endtask
  initial begin
    cyc(4);
    reset_n = 1'b1;
    s_regs();
    s_touch();
    s_wake();
    s_lowbat();
    s_cut();
    final_report();
  end
endmodule
`default_nettype wire
